/* pco_load_model.sv */
`timescale 1ns/1ps
// A load on one physical output; it only tallies switch-on events.
module pco_load_model
(
   input  wire logic         clk,   // System clock.
   input  wire logic         rst_n, // Tally clear, active low.
   input  wire logic         drive, // Output driving this load.
   output logic      [15:0]  ons    // Switch-on events seen.
);
   logic drive_r;

   // The tally clears with the device reset so that it lines up with the monitors.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         drive_r <= 1'h0;
         ons     <= 16'h0000;
      end
      else
      begin
         drive_r <= drive;
         if (drive && !drive_r)
            ons <= ons + 16'h0001;
      end
   end
endmodule

/* pco_on_counter.sv */
`timescale 1ns/1ps
// Counts rising edges of one output, reports thousands and raises an alarm.
module pco_on_counter
(
   input  wire logic                         clk,       // System clock.
   input  wire logic                         rst_n,     // Async reset, active low.
   input  wire logic                         out_level, // Output being counted.
   input  wire logic [pco_pkg::THR_W-1:0]    alarm_thr, // Alarm threshold in thousands.
   output logic      [pco_pkg::THR_W-1:0]    monitor,   // Count divided by one thousand.
   output logic                              alarm      // Threshold exceeded.
);

   logic                        prev_r;
   logic [pco_pkg::ACT_W-1:0]   unit_r;
   logic [pco_pkg::THR_W-1:0]   kilo_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_r <= 1'b0;
      else
         prev_r <= out_level;
   end

   // Units roll over into thousands so no divider is needed; the thousand count saturates.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         unit_r <= '0;
         kilo_r <= '0;
      end
      else if (out_level && !prev_r)
      begin
         if (unit_r == pco_pkg::ON_UNIT - 24'h000001)
         begin
            unit_r <= '0;
            if (kilo_r != {pco_pkg::THR_W{1'b1}})
               kilo_r <= kilo_r + 14'h0001;
         end
         else
            unit_r <= unit_r + 24'h000001;
      end
   end

   assign monitor = kilo_r;

   // Exceeding means more than thr*1000 activations, i.e. kilo above thr or equal with units.
   assign alarm = (alarm_thr != '0) &&
                  ((kilo_r > alarm_thr) || ((kilo_r == alarm_thr) && (unit_r != '0)));

endmodule

/* pco_output_logic.sv */
`timescale 1ns/1ps
module pco_output_logic
(
   input  wire logic                              CLK_SYS,         // System clock, 50 MHz.
   input  wire logic                              RST_N,           // Async reset, active low.
   input  wire pco_pkg::pco_cfg_e                 CFG,             // Counter configuration.
   input  wire logic                              SIX_DIGIT,       // Six-digit variant.
   input  wire logic                              FORECAST_SEL,    // First threshold is deviation.
   input  wire logic                              ALLOC_SWAP,      // Swap physical outputs.
   input  wire logic                              DUAL_SUB,        // Dual subtraction mode.
   input  wire logic                              HOLD_MODE,       // Self-holding output mode.
   input  wire pco_pkg::pco_colour_sel_e          COLOUR_SEL,      // Display colour setting.
   input  wire logic signed [pco_pkg::VAL_W-1:0]  COUNT_A,         // Present value of input A.
   input  wire logic signed [pco_pkg::VAL_W-1:0]  COUNT_B,         // Present value of input B.
   input  wire logic                              RESET_A,         // Reset one, from pin.
   input  wire logic                              RESET_B,         // Reset two, from pin.
   input  wire logic                              BATCH_RESET,     // Batch reset, from pin.
   input  wire pco_pkg::pco_limits_s              LIMITS_IN,       // Limit settings.
   input  wire logic                              LIMITS_WR,       // Store limits.
   input  wire pco_pkg::pco_setvals_s             SETVALS_IN,      // Set value entry.
   input  wire logic                              SETVALS_WR,      // Enter set values.
   input  wire logic [pco_pkg::THR_W-1:0]         ALARM_THR_CTRL,  // Control output alarm.
   input  wire logic [pco_pkg::THR_W-1:0]         ALARM_THR_1,     // First output alarm.
   input  wire logic [pco_pkg::THR_W-1:0]         ALARM_THR_2,     // Second output alarm.
   output logic                                   TRANSISTOR_OUT,  // Transistor output.
   output logic                                   CONTACT_OUT,     // Contact output.
   output pco_pkg::pco_lamp_e                     DISPLAY_COLOUR,  // Present value colour.
   output logic                                   SET_REFUSED,     // Last entry was refused.
   output logic [pco_pkg::VAL_W-1:0]              BATCH_COUNT,     // Batch completions.
   output logic signed [pco_pkg::VAL_W-1:0]       DUAL_VALUE,      // Dual count value.
   output logic [pco_pkg::THR_W-1:0]              MONITOR_CTRL,    // Control count, thousands.
   output logic [pco_pkg::THR_W-1:0]              MONITOR_1,       // First output, thousands.
   output logic [pco_pkg::THR_W-1:0]              MONITOR_2,       // Second output, thousands.
   output logic                                   ON_ALARM         // Activation alarm.
);

   logic [2:0]                    rst_a_s_r;
   logic [2:0]                    rst_b_s_r;
   logic [1:0]                    brst_s_r;
   pco_pkg::pco_limits_s          limits_r;
   pco_pkg::pco_setvals_s         sv_r;
   logic                          refused_r;
   logic                          first_output_r;
   logic                          second_output_r;
   logic                          hit1;
   logic                          hit2;
   logic                          done_prev_r;
   logic [pco_pkg::VAL_W-1:0]     batch_r;
   logic                          batch_out_r;
   logic signed [pco_pkg::VAL_W-1:0] dual_nxt;
   logic signed [pco_pkg::VAL_W-1:0] fc_point;
   logic [pco_pkg::LIM_W-1:0]     lim_max;
   logic                          colour_on;
   pco_pkg::pco_lamp_e            colour_nxt;
   logic [pco_pkg::THR_W-1:0]     mon_c;
   logic [pco_pkg::THR_W-1:0]     mon_1;
   logic [pco_pkg::THR_W-1:0]     mon_2;
   logic                          al_c;
   logic                          al_1;
   logic                          al_2;
   logic                          two_out;
   logic                          ctrl_level;

   // Pins are asynchronous; bit 0 is the first synchroniser stage, bit 2 a delayed copy.
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_a_s_r <= '0;
         rst_b_s_r <= '0;
         brst_s_r  <= '0;
      end
      else
      begin
         rst_a_s_r <= {rst_a_s_r[1:0], RESET_A};
         rst_b_s_r <= {rst_b_s_r[1:0], RESET_B};
         brst_s_r  <= {brst_s_r[0], BATCH_RESET};
      end
   end

   assign lim_max = SIX_DIGIT ? pco_pkg::LIMIT_MAX6 : pco_pkg::LIMIT_MAX4;

   // Limits outside the variant range are clamped rather than refused.
   function automatic logic [pco_pkg::LIM_W-1:0] clamp_lim
   (
      input logic [pco_pkg::LIM_W-1:0] v,
      input logic [pco_pkg::LIM_W-1:0] mx
   );
      if (v < pco_pkg::LIMIT_MIN)
         return pco_pkg::LIMIT_MIN;
      else if (v > mx)
         return mx;
      else
         return v;
   endfunction

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         limits_r.set_limit      <= pco_pkg::LIMIT_MAX6;
         limits_r.forecast_limit <= pco_pkg::LIMIT_MAX6;
         limits_r.batch_limit    <= pco_pkg::LIMIT_MAX6;
      end
      else if (LIMITS_WR)
      begin
         limits_r.set_limit      <= clamp_lim(LIMITS_IN.set_limit, lim_max);
         limits_r.forecast_limit <= clamp_lim(LIMITS_IN.forecast_limit, lim_max);
         limits_r.batch_limit    <= clamp_lim(LIMITS_IN.batch_limit, lim_max);
      end
   end

   // A whole entry is refused when any field breaks its limit, so values never mix.
   logic entry_bad;
   always_comb
   begin
      entry_bad = 1'b0;
      if ((SETVALS_IN.first_threshold > $signed({1'b0, limits_r.set_limit})) ||
          (SETVALS_IN.second_threshold > $signed({1'b0, limits_r.set_limit})) ||
          (SETVALS_IN.dual_threshold > $signed({1'b0, limits_r.set_limit})))
         entry_bad = 1'b1;
      if (SETVALS_IN.forecast_dev > {1'b0, limits_r.forecast_limit})
         entry_bad = 1'b1;
      if (SETVALS_IN.batch_threshold > {1'b0, limits_r.batch_limit})
         entry_bad = 1'b1;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sv_r      <= '0;
         refused_r <= 1'b0;
      end
      else if (SETVALS_WR)
      begin
         refused_r <= entry_bad;
         if (!entry_bad)
            sv_r <= SETVALS_IN;
      end
   end

   assign dual_nxt = DUAL_SUB ? (COUNT_A - COUNT_B) : (COUNT_A + COUNT_B);
   assign fc_point = sv_r.second_threshold - $signed(sv_r.forecast_dev);

   // Comparisons are combinational and registered twice, in the stage and at the pin, giving two cycles of latency, three in dual.
   always_comb
   begin
      hit1 = 1'b0;
      hit2 = 1'b0;
      case (CFG)
         pco_pkg::CFG_TWO_STAGE:
         begin
            if (FORECAST_SEL)
            begin
               if ($signed(sv_r.forecast_dev) >= sv_r.second_threshold)
                  hit1 = 1'b1;
               else
                  hit1 = (COUNT_A >= fc_point);
            end
            else
               hit1 = (COUNT_A >= sv_r.first_threshold);
            hit2 = (COUNT_A >= sv_r.second_threshold);
         end
         pco_pkg::CFG_DUAL:
         begin
            hit1 = (DUAL_VALUE >= sv_r.dual_threshold);
            hit2 = hit1;
         end
         pco_pkg::CFG_TWIN:
         begin
            hit1 = (COUNT_A >= sv_r.first_threshold);
            hit2 = (COUNT_B >= sv_r.second_threshold);
         end
         pco_pkg::CFG_ONE_STAGE, pco_pkg::CFG_TOTAL, pco_pkg::CFG_BATCH:
         begin
            hit1 = (COUNT_A >= sv_r.first_threshold);
            hit2 = hit1;
         end
         default:
         begin
            hit1 = 1'b0;
            hit2 = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         DUAL_VALUE <= '0;
      else
         DUAL_VALUE <= dual_nxt;
   end

   // Second stage; in twin it follows only reset two.
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         second_output_r <= 1'b0;
      else if ((CFG == pco_pkg::CFG_TWIN) ? rst_b_s_r[1] : rst_a_s_r[1])
         second_output_r <= 1'b0;
      else if (HOLD_MODE)
         second_output_r <= second_output_r | hit2;
      else
         second_output_r <= hit2;
   end

   // First stage; batch configuration turns it into the batch output.
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         first_output_r <= 1'b0;
      else if (CFG == pco_pkg::CFG_BATCH)
         first_output_r <= batch_out_r;
      else if (rst_a_s_r[1])
         first_output_r <= 1'b0;
      else if (HOLD_MODE)
         first_output_r <= first_output_r | hit1;
      else
         first_output_r <= hit1;
   end

   // Completion is the rising edge of the main compare.
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         done_prev_r <= 1'b0;
      else
         done_prev_r <= hit2;
   end

   // Batch output holds once set; a zero threshold never sets it.
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         batch_r     <= '0;
         batch_out_r <= 1'b0;
      end
      else if (brst_s_r[1])
      begin
         batch_r     <= '0;
         batch_out_r <= 1'b0;
      end
      else
      begin
         if (CFG == pco_pkg::CFG_BATCH && hit2 && !done_prev_r && !rst_a_s_r[2])
            batch_r <= batch_r + 21'h000001;
         if ((sv_r.batch_threshold != '0) && (batch_r >= sv_r.batch_threshold))
            batch_out_r <= 1'b1;
      end
   end

   assign two_out = (CFG == pco_pkg::CFG_TWO_STAGE);

   always_comb
   begin
      if (CFG == pco_pkg::CFG_TWIN)
         colour_on = first_output_r | second_output_r;
      else if (two_out)
         colour_on = second_output_r;
      else
         colour_on = first_output_r;
   end

   always_comb
   begin
      case (COLOUR_SEL)
         pco_pkg::COL_RED:          colour_nxt = pco_pkg::LAMP_RED;
         pco_pkg::COL_GREEN:        colour_nxt = pco_pkg::LAMP_GREEN;
         pco_pkg::COL_ORANGE:       colour_nxt = pco_pkg::LAMP_ORANGE;
         pco_pkg::COL_RED_GREEN:
            colour_nxt = colour_on ? pco_pkg::LAMP_GREEN : pco_pkg::LAMP_RED;
         pco_pkg::COL_GREEN_RED:
            colour_nxt = colour_on ? pco_pkg::LAMP_RED : pco_pkg::LAMP_GREEN;
         pco_pkg::COL_RED_ORANGE:
            colour_nxt = colour_on ? pco_pkg::LAMP_ORANGE : pco_pkg::LAMP_RED;
         pco_pkg::COL_ORANGE_RED:
            colour_nxt = colour_on ? pco_pkg::LAMP_RED : pco_pkg::LAMP_ORANGE;
         pco_pkg::COL_GREEN_ORANGE:
            colour_nxt = colour_on ? pco_pkg::LAMP_ORANGE : pco_pkg::LAMP_GREEN;
         pco_pkg::COL_ORANGE_GREEN:
            colour_nxt = colour_on ? pco_pkg::LAMP_GREEN : pco_pkg::LAMP_ORANGE;
         default:                   colour_nxt = pco_pkg::LAMP_RED;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         TRANSISTOR_OUT <= 1'b0;
         CONTACT_OUT    <= 1'b0;
         DISPLAY_COLOUR <= pco_pkg::LAMP_RED;
      end
      else
      begin
         TRANSISTOR_OUT <= ALLOC_SWAP ? second_output_r : first_output_r;
         CONTACT_OUT    <= ALLOC_SWAP ? first_output_r : second_output_r;
         DISPLAY_COLOUR <= colour_nxt;
      end
   end

   assign ctrl_level = first_output_r | second_output_r;

   pco_on_counter u_cnt_ctrl
   (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .out_level (ctrl_level),                                                     
      .alarm_thr (ALARM_THR_CTRL),
      .monitor   (mon_c),
      .alarm     (al_c)
   );

   pco_on_counter u_cnt_1
   (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .out_level (first_output_r),
      .alarm_thr (ALARM_THR_1),
      .monitor   (mon_1),
      .alarm     (al_1)
   );

   pco_on_counter u_cnt_2
   (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .out_level (second_output_r),
      .alarm_thr (ALARM_THR_2),
      .monitor   (mon_2),
      .alarm     (al_2)
   );

   // Thresholds above the settable range are ignored as if zero.
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         MONITOR_CTRL <= '0;
         MONITOR_1    <= '0;
         MONITOR_2    <= '0;
         ON_ALARM     <= 1'b0;
         SET_REFUSED  <= 1'b0;
         BATCH_COUNT  <= '0;
      end
      else
      begin
         MONITOR_CTRL <= mon_c;
         MONITOR_1    <= mon_1;
         MONITOR_2    <= mon_2;
         ON_ALARM     <= (al_c && ALARM_THR_CTRL <= pco_pkg::ALARM_MAX) ||
                         (two_out && ((al_1 && ALARM_THR_1 <= pco_pkg::ALARM_MAX) ||
                                      (al_2 && ALARM_THR_2 <= pco_pkg::ALARM_MAX)));
         SET_REFUSED  <= refused_r;
         BATCH_COUNT  <= batch_r;
      end
   end

endmodule

/* pco_output_logic_props.sv */
`timescale 1ns/1ps
module pco_output_logic_props
(
   input wire logic                             CLK_SYS,        // System clock.
   input wire logic                             RST_N,          // Async reset, active low.
   input wire pco_pkg::pco_cfg_e                CFG,            // Configuration.
   input wire logic                             ALLOC_SWAP,     // Output swap.
   input wire logic                             DUAL_SUB,       // Dual subtraction.
   input wire pco_pkg::pco_colour_sel_e         COLOUR_SEL,     // Colour setting.
   input wire logic signed [pco_pkg::VAL_W-1:0] COUNT_A,        // Value A.
   input wire logic signed [pco_pkg::VAL_W-1:0] COUNT_B,        // Value B.
   input wire logic                             BATCH_RESET,    // Batch reset pin.
   input wire logic                             SETVALS_WR,     // Set entry.
   input wire logic                             TRANSISTOR_OUT, // Transistor pin.
   input wire logic                             CONTACT_OUT,    // Contact pin.
   input wire pco_pkg::pco_lamp_e               DISPLAY_COLOUR, // Colour shown.
   input wire logic                             SET_REFUSED,    // Entry refused.
   input wire logic [pco_pkg::VAL_W-1:0]        BATCH_COUNT,    // Batch count.
   input wire logic signed [pco_pkg::VAL_W-1:0] DUAL_VALUE,     // Dual value.
   input wire logic [pco_pkg::THR_W-1:0]        MONITOR_CTRL    // Control monitor.
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   a_fixed_colour: assert property (
      $past(RST_N) && $past(COLOUR_SEL) == pco_pkg::COL_GREEN
      |-> DISPLAY_COLOUR == pco_pkg::LAMP_GREEN)
      else $error("Fixed green setting not shown");
   a_stage_colour: assert property (
      $past(RST_N) && $past(CFG) == pco_pkg::CFG_TWO_STAGE
      && $past(COLOUR_SEL) == pco_pkg::COL_GREEN_ORANGE
      |-> DISPLAY_COLOUR == (($past(ALLOC_SWAP) ? TRANSISTOR_OUT : CONTACT_OUT)
         ? pco_pkg::LAMP_ORANGE : pco_pkg::LAMP_GREEN))
      else $error("Two-stage colour does not follow second output");
   a_twin_colour: assert property (
      $past(RST_N) && $past(CFG) == pco_pkg::CFG_TWIN
      && $past(COLOUR_SEL) == pco_pkg::COL_RED_GREEN
      |-> DISPLAY_COLOUR == ((TRANSISTOR_OUT || CONTACT_OUT)
         ? pco_pkg::LAMP_GREEN : pco_pkg::LAMP_RED))
      else $error("Twin colour does not follow either output");
   a_refuse_timing: assert property (
      $changed(SET_REFUSED) |-> $past(SETVALS_WR, 2))
      else $error("Refusal flag moved without an entry");
   a_monitor_step: assert property (
      MONITOR_CTRL - $past(MONITOR_CTRL) <= 14'h0001)
      else $error("Control monitor fell or jumped");
   a_batch_clear: assert property (
      BATCH_RESET [*4] |=> BATCH_COUNT == 21'h000000)
      else $error("Batch count not cleared by batch reset");
   a_batch_only: assert property (
      $past(CFG) != pco_pkg::CFG_BATCH && $past(CFG, 2) != pco_pkg::CFG_BATCH
      && $past(CFG, 3) != pco_pkg::CFG_BATCH |-> BATCH_COUNT <= $past(BATCH_COUNT))
      else $error("Batch count grew outside batch configuration");
   a_dual_value: assert property (
      $past(RST_N) && $past(CFG) == pco_pkg::CFG_DUAL
      |-> DUAL_VALUE == ($past(DUAL_SUB) ? $past(COUNT_A) - $past(COUNT_B)
         : $past(COUNT_A) + $past(COUNT_B)))
      else $error("Dual value wrong");
endmodule

bind pco_output_logic pco_output_logic_props i_props
(
   .CLK_SYS, .RST_N, .CFG, .ALLOC_SWAP, .DUAL_SUB, .COLOUR_SEL, .COUNT_A, .COUNT_B,
   .BATCH_RESET, .SETVALS_WR, .TRANSISTOR_OUT, .CONTACT_OUT, .DISPLAY_COLOUR,
   .SET_REFUSED, .BATCH_COUNT, .DUAL_VALUE, .MONITOR_CTRL
);

/* pco_pkg.sv */
package pco_pkg;

   localparam int VAL_W    = 21;
   localparam int ACT_W    = 24;
   localparam int THR_W    = 14;
   localparam int LIM_W    = 20;
   localparam int COLOUR_W = 4;

   localparam logic [LIM_W-1:0] LIMIT_MIN   = 20'h00001;
   localparam logic [LIM_W-1:0] LIMIT_MAX4  = 20'h0270F;
   localparam logic [LIM_W-1:0] LIMIT_MAX6  = 20'hF423F;
   localparam logic [THR_W-1:0] ALARM_MAX   = 14'h270F;
   localparam logic [ACT_W-1:0] ON_UNIT     = 24'h0003E8;
   localparam logic [ACT_W-1:0] ACT_MAX     = 24'hFFFFFF;

   typedef enum logic [2:0]
   {
      CFG_ONE_STAGE,
      CFG_TWO_STAGE,
      CFG_TOTAL,
      CFG_BATCH,
      CFG_DUAL,
      CFG_TWIN
   } pco_cfg_e;

   typedef enum logic [3:0]
   {
      COL_RED,
      COL_GREEN,
      COL_ORANGE,
      COL_RED_GREEN,
      COL_GREEN_RED,
      COL_RED_ORANGE,
      COL_ORANGE_RED,
      COL_GREEN_ORANGE,
      COL_ORANGE_GREEN
   } pco_colour_sel_e;

   typedef enum logic [1:0]
   {
      LAMP_RED,
      LAMP_GREEN,
      LAMP_ORANGE
   } pco_lamp_e;

   typedef struct packed
   {
      logic signed [VAL_W-1:0] first_threshold;
      logic signed [VAL_W-1:0] second_threshold;
      logic [VAL_W-1:0]        forecast_dev;
      logic [VAL_W-1:0]        batch_threshold;
      logic signed [VAL_W-1:0] dual_threshold;
   } pco_setvals_s;

   typedef struct packed
   {
      logic [LIM_W-1:0] set_limit;
      logic [LIM_W-1:0] forecast_limit;
      logic [LIM_W-1:0] batch_limit;
   } pco_limits_s;

endpackage

/* tb_pco_output_logic.sv */
`timescale 1ns/1ps
module tb_pco_output_logic;
   logic                             CLK_SYS = 1'h0, RST_N = 1'h0, SIX_DIGIT = 1'h1;
   logic                             FORECAST_SEL = 1'h0, ALLOC_SWAP = 1'h0, DUAL_SUB = 1'h0;
   logic                             HOLD_MODE = 1'h0, RESET_A = 1'h0, RESET_B = 1'h0;
   logic                             BATCH_RESET = 1'h0, LIMITS_WR = 1'h0, SETVALS_WR = 1'h0;
   logic                             TRANSISTOR_OUT, CONTACT_OUT, SET_REFUSED, ON_ALARM;
   pco_pkg::pco_cfg_e                CFG = pco_pkg::CFG_TWO_STAGE;
   pco_pkg::pco_colour_sel_e         COLOUR_SEL = pco_pkg::COL_RED;
   pco_pkg::pco_lamp_e               DISPLAY_COLOUR;
   pco_pkg::pco_limits_s             LIMITS_IN = '0;
   pco_pkg::pco_setvals_s            SETVALS_IN = '0;
   logic signed [pco_pkg::VAL_W-1:0] COUNT_A = '0, COUNT_B = '0, DUAL_VALUE;
   logic [pco_pkg::VAL_W-1:0]        BATCH_COUNT;
   logic [pco_pkg::THR_W-1:0]        ALARM_THR_CTRL = '0, ALARM_THR_1 = '0, ALARM_THR_2 = '0;
   logic [pco_pkg::THR_W-1:0]        MONITOR_CTRL, MONITOR_1, MONITOR_2;
   logic [15:0]                      tr_ons;
   int                               fail_count = 0, n_tests = 0, cycles = 0;

   pco_output_logic i_dut
   (
      .CLK_SYS, .RST_N, .CFG, .SIX_DIGIT, .FORECAST_SEL, .ALLOC_SWAP, .DUAL_SUB, .HOLD_MODE,
      .COLOUR_SEL, .COUNT_A, .COUNT_B, .RESET_A, .RESET_B, .BATCH_RESET, .LIMITS_IN,
      .LIMITS_WR, .SETVALS_IN, .SETVALS_WR, .ALARM_THR_CTRL, .ALARM_THR_1, .ALARM_THR_2,
      .TRANSISTOR_OUT, .CONTACT_OUT, .DISPLAY_COLOUR, .SET_REFUSED, .BATCH_COUNT,
      .DUAL_VALUE, .MONITOR_CTRL, .MONITOR_1, .MONITOR_2, .ON_ALARM
   );
   pco_load_model i_load
   (
      .clk(CLK_SYS), .rst_n(RST_N), .drive(TRANSISTOR_OUT), .ons(tr_ons)
   );

   always #10 CLK_SYS = ~CLK_SYS;

   always @(posedge CLK_SYS)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic set_pv(input logic [20:0] a, input logic [20:0] b);
      COUNT_A = a;
      COUNT_B = b;
      tick(4);
   endtask

   task automatic entry(input logic [20:0] f, s, d, b, input logic bad);
      SETVALS_IN = '{f, s, d, b, s};
      SETVALS_WR = 1'h1;
      tick(1);
      SETVALS_WR = 1'h0;
      tick(2);
      chk(SET_REFUSED, bad);
   endtask

   initial
   begin
      tick(16);
      RST_N = 1'h1;
      tick(1);
      chk(DISPLAY_COLOUR, pco_pkg::LAMP_RED);
      LIMITS_IN = '{20'h00064, 20'h00064, 20'h00005};
      LIMITS_WR = 1'h1;
      tick(1);
      LIMITS_WR = 1'h0;
      entry(21'h00032, 21'h00064, 21'h0000A, 21'h00005, 1'h0);
      entry(21'h00032, 21'h00065, 21'h0000A, 21'h00002, 1'h1);
      entry(21'h00032, 21'h00064, 21'h00065, 21'h00002, 1'h1);
      entry(21'h00032, 21'h00064, 21'h0000A, 21'h00006, 1'h1);
      entry(21'h00032, 21'h00064, 21'h0000A, 21'h00002, 1'h0);
      COLOUR_SEL = pco_pkg::COL_GREEN_ORANGE;
      for (int k = 0; k < 2; k++)
      begin
         ALLOC_SWAP = k[0];
         set_pv(21'h00032, 21'h00000);
         chk({TRANSISTOR_OUT, CONTACT_OUT}, k ? 2'h1 : 2'h2);
         chk(DISPLAY_COLOUR, pco_pkg::LAMP_GREEN);
         set_pv(21'h00064, 21'h00000);
         chk(k ? TRANSISTOR_OUT : CONTACT_OUT, 1'h1);
         chk(DISPLAY_COLOUR, pco_pkg::LAMP_ORANGE);
         set_pv(21'h00000, 21'h00000);
      end
      ALLOC_SWAP = 1'h0;
      FORECAST_SEL = 1'h1;
      set_pv(21'h0005A, 21'h00000);
      chk(TRANSISTOR_OUT, 1'h1);
      set_pv(21'h00059, 21'h00000);
      chk(TRANSISTOR_OUT, 1'h0);
      entry(21'h00032, 21'h00064, 21'h00064, 21'h00002, 1'h0);
      set_pv(21'h00000, 21'h00000);
      chk(TRANSISTOR_OUT, 1'h1);
      FORECAST_SEL = 1'h0;
      entry(21'h00032, 21'h00064, 21'h0000A, 21'h00002, 1'h0);
      for (int k = 0; k < 3; k++)
      begin
         COLOUR_SEL = pco_pkg::pco_colour_sel_e'(k);
         tick(3);
         chk(DISPLAY_COLOUR, k);
      end
      CFG = pco_pkg::CFG_DUAL;
      for (int k = 0; k < 2; k++)
      begin
         DUAL_SUB = k[0];
         set_pv(21'h00046, 21'h0001E);
         chk(DUAL_VALUE, k ? 21'h00028 : 21'h00064);
         chk(TRANSISTOR_OUT, !k);
      end
      CFG = pco_pkg::CFG_TWIN;
      COLOUR_SEL = pco_pkg::COL_RED_GREEN;
      set_pv(21'h00032, 21'h00000);
      chk({TRANSISTOR_OUT, CONTACT_OUT}, 2'h2);
      set_pv(21'h00000, 21'h00032);
      chk({TRANSISTOR_OUT, CONTACT_OUT}, 2'h0);
      chk(DISPLAY_COLOUR, pco_pkg::LAMP_RED);
      HOLD_MODE = 1'h1;
      set_pv(21'h00032, 21'h00064);
      set_pv(21'h00000, 21'h00000);
      RESET_A = 1'h1;
      tick(4);
      RESET_A = 1'h0;
      tick(2);
      chk({TRANSISTOR_OUT, CONTACT_OUT}, 2'h1);
      chk(DISPLAY_COLOUR, pco_pkg::LAMP_GREEN);
      RESET_B = 1'h1;
      tick(4);
      RESET_B = 1'h0;
      tick(2);
      chk({TRANSISTOR_OUT, CONTACT_OUT}, 2'h0);
      HOLD_MODE = 1'h0;
      CFG = pco_pkg::CFG_BATCH;
      repeat (2)
      begin
         set_pv(21'h00064, 21'h00000);
         set_pv(21'h00000, 21'h00000);
      end
      chk(BATCH_COUNT, 21'h00002);
      chk(TRANSISTOR_OUT, 1'h1);
      BATCH_RESET = 1'h1;
      tick(4);
      BATCH_RESET = 1'h0;
      tick(3);
      chk({BATCH_COUNT, TRANSISTOR_OUT}, 22'h000000);
      // A fresh reset keeps activations from earlier scenarios out of the tallies.
      CFG = pco_pkg::CFG_TWO_STAGE;
      // A negative value keeps the zeroed thresholds from firing the outputs after reset.
      COUNT_A = 21'h1FFFFF;
      RST_N = 1'h0;
      tick(2);
      RST_N = 1'h1;
      tick(1);
      entry(21'h00032, 21'h00064, 21'h0000A, 21'h00002, 1'h0);
      ALARM_THR_1 = 14'h0001;
      repeat (1000)
      begin
         set_pv(21'h00032, 21'h00000);
         set_pv(21'h00000, 21'h00000);
      end
      chk({MONITOR_CTRL, MONITOR_1, MONITOR_2}, 42'h00010004000);
      chk(ON_ALARM, 1'h0);
      set_pv(21'h00032, 21'h00000);
      tick(3);
      chk(ON_ALARM, 1'h1);
      chk(tr_ons, 16'h03E9);
      ALARM_THR_1 = 14'h0000;
      tick(3);
      chk(ON_ALARM, 1'h0);
      ALARM_THR_CTRL = 14'h0001;
      tick(3);
      chk(ON_ALARM, 1'h1);
      // On the four-digit variant a stored limit is clamped to 9999.
      SIX_DIGIT = 1'h0;
      LIMITS_IN = '{20'hFFFFF, 20'hFFFFF, 20'hFFFFF};
      LIMITS_WR = 1'h1;
      tick(1);
      LIMITS_WR = 1'h0;
      entry(21'h00032, 21'h02710, 21'h0000A, 21'h00002, 1'h1);
      final_report();
   end
endmodule
